/* File: logic/tw_master.sv */
// Two-wire bus master with command queue, stretching and arbitration.
`default_nettype none

module tw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("tw_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
    out_valid = wr_ptr_reg != rd_ptr_reg;
    out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_ptr_next = push ? wr_ptr_reg + (AW + 1)'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + (AW + 1)'(1) : rd_ptr_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

module tw_master #(
  parameter int HALF_CYC = tw_pkg::HALF_BIT_CYC,
  parameter int Q_DEPTH  = tw_pkg::CMDQ_DEPTH
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic           retry_on_loss,
  input  wire logic           cmd_valid,
  output logic                cmd_ready,
  input  wire tw_pkg::tw_cmd_t cmd,
  output logic                rsp_valid,
  output tw_pkg::tw_rsp_t     rsp,
  output logic                bus_busy,
  output logic                bus_owned,
  input  wire logic           scl_i,
  output logic                scl_o,
  output logic                scl_oe,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe
);
  localparam int CW = $clog2(HALF_CYC + 1);

  initial begin
    if (HALF_CYC < tw_pkg::SDA_CHANGE_CYC + 2)
      $error("tw_master: HALF_CYC too small");
  end

  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_HOLD  = 12'h002,
    ST_RS_A  = 12'h004,
    ST_RS_B  = 12'h008,
    ST_ST_A  = 12'h010,
    ST_ST_B  = 12'h020,
    ST_LOW   = 12'h040,
    ST_HIGH  = 12'h080,
    ST_SP_A  = 12'h100,
    ST_SP_B  = 12'h200,
    ST_SP_C  = 12'h400,
    ST_WFREE = 12'h800
  } tw_state_t;

  tw_state_t       state_reg, state_next;
  logic [CW-1:0]   cnt_reg, cnt_next;
  logic [3:0]      bit_reg, bit_next;
  logic [8:0]      sh_reg, sh_next;
  logic [8:0]      rx_reg, rx_next;
  logic [7:0]      addr_reg, addr_next;
  logic            scl_drv_reg, scl_drv_next;
  logic            sda_drv_reg, sda_drv_next;
  logic            tx_reg, tx_next;
  logic            owned_reg, owned_next;
  logic            need_addr_reg, need_addr_next;
  logic            addr_sent_reg, addr_sent_next;
  logic            replay_reg, replay_next;
  logic            drop_reg, drop_next;
  logic            rsp_v_reg, rsp_v_next;
  tw_pkg::tw_rsp_t rsp_reg, rsp_next;
  logic            busy_reg, busy_next;
  logic            scl_meta_reg, scl_s_reg, scl_d_reg;
  logic            sda_meta_reg, sda_s_reg, sda_d_reg;
  logic            q_valid, q_ready;
  tw_pkg::tw_cmd_t q_cmd;
  logic            half_done, arb_lost, start_det, stop_det;

  tw_fifo #(
    .WIDTH ($bits(tw_pkg::tw_cmd_t)),
    .DEPTH (Q_DEPTH)
  ) u_cmdq (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_cmd)
  );

  // Open-drain pins: only ever pull low
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_drv_reg;
  assign sda_oe    = sda_drv_reg;
  assign rsp_valid = rsp_v_reg;
  assign rsp       = rsp_reg;
  assign bus_busy  = busy_reg;
  assign bus_owned = owned_reg;

  assign half_done = cnt_reg == CW'(HALF_CYC - 1);
  assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
  assign stop_det  = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
  // loss only on differing data bits
  assign arb_lost  = (state_reg == ST_HIGH) && scl_s_reg && tx_reg &&
                     (bit_reg < 4'(tw_pkg::ACK_INDEX)) &&
                     !sda_drv_reg && !sda_s_reg;

  // busy from any START until a STOP seen on the wires
  always_comb begin
    busy_next = busy_reg;
    if (start_det || owned_next) begin
      busy_next = 1'b1;
    end else if (stop_det) begin
      busy_next = 1'b0;
    end
  end

  always_comb begin
    state_next     = state_reg;
    cnt_next       = half_done ? '0 : cnt_reg + CW'(1);
    bit_next       = bit_reg;
    sh_next        = sh_reg;
    rx_next        = rx_reg;
    addr_next      = addr_reg;
    scl_drv_next   = scl_drv_reg;
    sda_drv_next   = sda_drv_reg;
    tx_next        = tx_reg;
    owned_next     = owned_reg;
    need_addr_next = need_addr_reg;
    addr_sent_next = addr_sent_reg;
    replay_next    = replay_reg;
    drop_next      = drop_reg;
    rsp_v_next     = 1'b0;
    rsp_next       = rsp_reg;
    q_ready        = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (q_valid && q_cmd.op == tw_pkg::TW_OP_START) begin
          // Wait for a free bus before taking a START
          if (!busy_reg) begin
            q_ready   = 1'b1;
            drop_next = 1'b0;
            state_next = ST_RS_A;
          end
        end else if (q_valid) begin
          q_ready = 1'b1;
          if (!drop_reg) begin
            rsp_v_next = 1'b1;
            rsp_next   = '{data: 8'h00, ack: 1'b0, lost: 1'b0, err: 1'b1};
          end
        end
      end
      ST_HOLD: begin
        cnt_next = '0;
        if (q_valid) begin
          q_ready = 1'b1;
          case (q_cmd.op)
            // START while owned is a repeated START
            tw_pkg::TW_OP_START: begin
              sda_drv_next = 1'b0;
              state_next   = ST_RS_A;
            end
            // first write after START is the address packet
            tw_pkg::TW_OP_WRITE: begin
              sh_next        = {q_cmd.data, 1'b1};
              tx_next        = 1'b1;
              bit_next       = tw_pkg::BIT_CNT_RESET;
              addr_next      = need_addr_reg ? q_cmd.data : addr_reg;
              need_addr_next = 1'b0;
              addr_sent_next = 1'b1;
              state_next     = ST_LOW;
            end
            // caller's nack flag answers the last wanted byte
            tw_pkg::TW_OP_READ: begin
              if (addr_sent_reg) begin
                sh_next    = {8'hFF, q_cmd.nack};
                tx_next    = 1'b0;
                bit_next   = tw_pkg::BIT_CNT_RESET;
                state_next = ST_LOW;
              end else begin
                rsp_v_next = 1'b1;
                rsp_next   = '{data: 8'h00, ack: 1'b0, lost: 1'b0,
                               err: 1'b1};
              end
            end
            default: begin
              // STOP refused until an address went out
              if (addr_sent_reg) begin
                sda_drv_next = 1'b1;
                state_next   = ST_SP_A;
              end else begin
                rsp_v_next = 1'b1;
                rsp_next   = '{data: 8'h00, ack: 1'b0, lost: 1'b0,
                               err: 1'b1};
              end
            end
          endcase
        end
      end
      ST_RS_A: begin
        if (half_done) begin
          scl_drv_next = 1'b0;
          state_next   = ST_RS_B;
        end
      end
      ST_RS_B: begin
        // hold the count while SCL is still held low
        cnt_next = !scl_s_reg ? cnt_reg : cnt_next;
        if (scl_s_reg && half_done) begin
          sda_drv_next   = 1'b1;
          owned_next     = 1'b1;
          need_addr_next = 1'b1;
          addr_sent_next = 1'b0;
          state_next     = ST_ST_A;
        end
      end
      ST_ST_A: begin
        if (half_done) begin
          scl_drv_next = 1'b1;
          state_next   = ST_ST_B;
        end
      end
      ST_ST_B: begin
        if (half_done) begin
          state_next = ST_HOLD;
          // replay the address after a lost arbitration
          if (replay_reg) begin
            replay_next    = 1'b0;
            sh_next        = {addr_reg, 1'b1};
            tx_next        = 1'b1;
            bit_next       = tw_pkg::BIT_CNT_RESET;
            need_addr_next = 1'b0;
            addr_sent_next = 1'b1;
            state_next     = ST_LOW;
          end
        end
      end
      ST_LOW: begin
        // SDA changes only after SCL is low
        if (cnt_reg == CW'(tw_pkg::SDA_CHANGE_CYC)) begin
          sda_drv_next = !sh_reg[8];
        end
        if (half_done) begin
          scl_drv_next = 1'b0;
          state_next   = ST_HIGH;
        end
      end
      ST_HIGH: begin
        // high phase counted only once SCL is really high
        cnt_next = !scl_s_reg ? cnt_reg : cnt_next;
        if (arb_lost) begin
          scl_drv_next = 1'b0;
          sda_drv_next = 1'b0;
          owned_next   = 1'b0;
          cnt_next     = '0;
          rsp_v_next   = 1'b1;
          rsp_next     = '{data: 8'h00, ack: 1'b0, lost: 1'b1, err: 1'b0};
          // software picks restart or unaddressed fallback
          replay_next  = retry_on_loss;
          drop_next    = !retry_on_loss;
          state_next   = retry_on_loss ? ST_WFREE : ST_IDLE;
        end else if (scl_s_reg && half_done) begin
          rx_next      = {rx_reg[7:0], sda_s_reg};
          sh_next      = {sh_reg[7:0], 1'b1};
          scl_drv_next = 1'b1;
          if (bit_reg == 4'(tw_pkg::ACK_INDEX)) begin
            state_next = ST_HOLD;
            rsp_v_next = 1'b1;
            // ack is a low SDA in the ninth clock
            rsp_next   = '{data: rx_reg[7:0], ack: !sda_s_reg,
                           lost: 1'b0, err: 1'b0};
          end else begin
            bit_next   = bit_reg + 4'h1;
            state_next = ST_LOW;
          end
        end
      end
      ST_SP_A: begin
        if (half_done) begin
          scl_drv_next = 1'b0;
          state_next   = ST_SP_B;
        end
      end
      ST_SP_B: begin
        cnt_next = !scl_s_reg ? cnt_reg : cnt_next;
        if (scl_s_reg && half_done) begin
          // Ownership ends at the STOP edge so the seen STOP can clear busy
          sda_drv_next   = 1'b0;
          owned_next     = 1'b0;
          addr_sent_next = 1'b0;
          state_next     = ST_SP_C;
        end
      end
      ST_SP_C: begin
        if (half_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_WFREE: begin
        cnt_next = '0;
        if (!busy_reg) begin
          state_next = ST_RS_A;
        end
      end
      default: begin
        state_next   = ST_IDLE;
        scl_drv_next = 1'b0;
        sda_drv_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= '0;
      bit_reg       <= tw_pkg::BIT_CNT_RESET;
      sh_reg        <= tw_pkg::SHIFT_RESET;
      rx_reg        <= '0;
      addr_reg      <= '0;
      scl_drv_reg   <= 1'b0;
      sda_drv_reg   <= 1'b0;
      tx_reg        <= 1'b0;
      owned_reg     <= 1'b0;
      need_addr_reg <= 1'b0;
      addr_sent_reg <= 1'b0;
      replay_reg    <= 1'b0;
      drop_reg      <= 1'b0;
      rsp_v_reg     <= 1'b0;
      rsp_reg       <= tw_pkg::RSP_RESET;
      busy_reg      <= 1'b0;
      scl_meta_reg  <= 1'b1;
      scl_s_reg     <= 1'b1;
      scl_d_reg     <= 1'b1;
      sda_meta_reg  <= 1'b1;
      sda_s_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      bit_reg       <= bit_next;
      sh_reg        <= sh_next;
      rx_reg        <= rx_next;
      addr_reg      <= addr_next;
      scl_drv_reg   <= scl_drv_next;
      sda_drv_reg   <= sda_drv_next;
      tx_reg        <= tx_next;
      owned_reg     <= owned_next;
      need_addr_reg <= need_addr_next;
      addr_sent_reg <= addr_sent_next;
      replay_reg    <= replay_next;
      drop_reg      <= drop_next;
      rsp_v_reg     <= rsp_v_next;
      rsp_reg       <= rsp_next;
      busy_reg      <= busy_next;
      // Wire levels cross into this clock through two flops
      scl_meta_reg  <= scl_i;
      scl_s_reg     <= scl_meta_reg;
      scl_d_reg     <= scl_s_reg;
      sda_meta_reg  <= sda_i;
      sda_s_reg     <= sda_meta_reg;
      sda_d_reg     <= sda_s_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_nine_bits;
    rsp_valid && !rsp.err && !rsp.lost |->
      $past(bit_reg) == 4'h8 && $past(state_reg) == ST_HIGH;
  endproperty
  a_nine_bits: assert property (p_nine_bits)
    else $error("byte answered after other than nine bits");

  property p_ack_drive;
    state_reg == ST_HIGH && !tx_reg && bit_reg == 4'h8 && !sh_reg[8]
      |-> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("ack not driven low in ninth clock");

  property p_nack_release;
    state_reg == ST_HIGH && !tx_reg && bit_reg == 4'h8 && sh_reg[8]
      |-> !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("nack not left high");

  property p_msb_first;
    state_reg == ST_HIGH |-> sda_oe == !sh_reg[8];
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("bit on SDA differs from shifter top bit");

  property p_no_empty;
    $rose(state_reg == ST_SP_A) |-> $past(addr_sent_reg);
  endproperty
  a_no_empty: assert property (p_no_empty)
    else $error("STOP issued without address packet");

  property p_stretch_wait;
    state_reg == ST_HIGH && !scl_s_reg && !arb_lost |=>
      state_reg == ST_HIGH && $stable(cnt_reg);
  endproperty
  a_stretch_wait: assert property (p_stretch_wait)
    else $error("high phase advanced while SCL held low");

  property p_high_len;
    $past(state_reg) == ST_HIGH && state_reg != ST_HIGH && !$past(arb_lost)
      |-> $past(cnt_reg) == CW'(HALF_CYC - 1);
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("SCL high phase length wrong");

  property p_owned_busy;
    owned_reg |-> busy_reg;
  endproperty
  a_owned_busy: assert property (p_owned_busy)
    else $error("bus owned but not marked busy");

  property p_lost_release;
    arb_lost |=> !scl_oe && !sda_oe && !owned_reg ##1 !scl_oe;
  endproperty
  a_lost_release: assert property (p_lost_release)
    else $error("lines not released after arbitration loss");

  property p_sda_stable_high;
    state_reg == ST_HIGH ##1 state_reg == ST_HIGH |-> $stable(sda_oe);
  endproperty
  a_sda_stable_high: assert property (p_sda_stable_high)
    else $error("SDA changed while SCL high");

  c_ack_byte: cover property (rsp_valid && rsp.ack && !rsp.err);
  c_arb_lost: cover property (rsp_valid && rsp.lost);
  c_rep_start: cover property (state_reg == ST_HOLD ##1
                               state_reg == ST_RS_A);
  c_retry: cover property (state_reg == ST_WFREE ##1
                           state_reg == ST_RS_A);
endmodule
`default_nettype wire

/* File: logic/tw_pkg.sv */
// Shared constants and carrier types for the two-wire bus master.
`default_nettype none
package tw_pkg;

  // System clock and bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_BIT_NS   = 5000;
  // Least time: round up to whole cycles
  localparam int HALF_BIT_CYC  =
    (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycle inside the low phase at which SDA may change
  localparam int SDA_CHANGE_CYC = 1;

  // Packet layout: eight data bits then one acknowledge bit
  localparam int BYTE_BITS   = 8;
  localparam int PACKET_BITS = 9;
  localparam int ACK_INDEX   = 8;

  // Command queue geometry
  localparam int CMDQ_DEPTH  = 16;

  // Reset values
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [8:0] SHIFT_RESET   = 9'h1FF;

  typedef enum logic [1:0] {
    TW_OP_START = 2'h0,
    TW_OP_WRITE = 2'h1,
    TW_OP_READ  = 2'h2,
    TW_OP_STOP  = 2'h3
  } tw_op_t;

  typedef struct packed {
    tw_op_t     op;
    logic [7:0] data;
    logic       nack;
  } tw_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ack;
    logic       lost;
    logic       err;
  } tw_rsp_t;

  localparam tw_rsp_t RSP_RESET = '{data: 8'h00, ack: 1'b0,
                                    lost: 1'b0, err: 1'b0};

endpackage
`default_nettype wire

/* File: test/tw_master_tb.sv */
// Self-checking bench for the two-wire bus master and its slave model.
`default_nettype none
module tw_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 8;
  localparam logic [7:0] AW = 8'h54;
  localparam logic [7:0] AR = 8'h55;
  localparam logic [7:0] RB = 8'hB4;
  typedef struct packed {
    tw_pkg::tw_op_t op;
    logic [7:0]     d;
    logic           nk;
    logic           want;
    logic           ack;
    logic           err;
  } tw_row_t;
  localparam tw_pkg::tw_op_t S = tw_pkg::TW_OP_START;
  localparam tw_pkg::tw_op_t W = tw_pkg::TW_OP_WRITE;
  localparam tw_pkg::tw_op_t R = tw_pkg::TW_OP_READ;
  localparam tw_pkg::tw_op_t P = tw_pkg::TW_OP_STOP;
  // Idle write and empty message must be refused before real traffic
  tw_row_t rows [14] = '{
    '{W, AW, 1'b0, 1'b1, 1'b0, 1'b1}, '{S, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{P, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1}, '{W, AW, 1'b0, 1'b1, 1'b1, 1'b0},
    '{W, 8'h5A, 1'b0, 1'b1, 1'b1, 1'b0}, '{W, 8'h81, 1'b0, 1'b1, 1'b1, 1'b0},
    '{S, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0}, '{W, AR, 1'b0, 1'b1, 1'b1, 1'b0},
    '{R, RB, 1'b0, 1'b1, 1'b1, 1'b0}, '{R, RB, 1'b1, 1'b1, 1'b0, 1'b0},
    '{P, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0}, '{S, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{W, 8'h22, 1'b0, 1'b1, 1'b0, 1'b0}, '{P, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0}};

  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic            retry_on_loss = 1'b0;
  logic            cmd_valid = 1'b0;
  tw_pkg::tw_cmd_t cmd = '0;
  logic            cmd_ready, rsp_valid, bus_busy, bus_owned;
  tw_pkg::tw_rsp_t rsp;
  logic            scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic            rival = 1'b0;
  logic [15:0]     stretch = 16'h0000;
  logic [7:0]      got;
  wire             scl_w;
  wire             sda_w;
  int              failures = 0;
  int              n_checks = 0;
  int              hcnt = 0, lcnt = 0, hl = 0, ll = 0, hs = 0, ls = 0, k;

  // Open-drain wires with pull-ups
  assign scl_w = !(scl_oe || s_scl_oe);
  assign sda_w = !(sda_oe || s_sda_oe || rival);

  initial begin
    forever #5 clk = ~clk;
  end

  tw_master #(.HALF_CYC(HC), .Q_DEPTH(tw_pkg::CMDQ_DEPTH)) dut (
    .clk(clk), .srst(srst), .retry_on_loss(retry_on_loss),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .bus_busy(bus_busy),
    .bus_owned(bus_owned), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));

  tw_slave_model #(.ADDR(7'h2A)) u_slave (
    .clk(clk), .scl(scl_w), .sda(sda_w), .stretch(stretch),
    .rd_byte(RB), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .got(got));

  // Length of the last completed high and low clock phases
  always @(posedge clk) begin
    if (scl_w) begin
      hcnt <= hcnt + 1;
      if (lcnt != 0) ll <= lcnt;
      lcnt <= 0;
    end else begin
      lcnt <= lcnt + 1;
      if (hcnt != 0) hl <= hcnt;
      hcnt <= 0;
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic push(input tw_pkg::tw_op_t op, input logic [7:0] d,
                      input logic nk);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op: op, data: d, nack: nk};
    for (n = 0; n < 2000 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (n == 2000) begin
      failures++;
      conclude();
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic wait_rsp();
    int n;
    @(negedge clk);
    for (n = 0; n < 20000 && rsp_valid !== 1'b1; n++) @(negedge clk);
    if (n == 20000) begin
      failures++;
      conclude();
    end
  endtask

  initial begin
    repeat (2) @(negedge clk);
    // Outputs idle and queue open during reset
    chk({scl_oe, sda_oe, rsp_valid, bus_busy, bus_owned, cmd_ready}, 6'h01);
    @(negedge clk);
    srst = 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      push(rows[i].op, rows[i].d, rows[i].nk);
      if (rows[i].want) begin
        wait_rsp();
        chk(rsp.err, rows[i].err);
        chk(rsp.lost, 1'b0);
        if (!rows[i].err) chk(rsp.ack, rows[i].ack);
        if (!rows[i].err) chk(rsp.data, rows[i].d);
        if (rows[i].op == W && !rows[i].err) chk(got, rows[i].d);
        if (i == 7) chk(bus_owned, 1'b1);
      end
    end
    repeat (80) @(negedge clk);
    chk({bus_busy, bus_owned}, 2'h0);
    $display("row test done");
    stretch = 16'h0190;
    push(S, 8'h00, 1'b0);
    push(W, AW, 1'b0);
    repeat (60) @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op: W, data: 8'h3C, nack: 1'b0};
    k = 0;
    for (int i = 0; i < 40; i++) begin
      if (cmd_ready === 1'b1) k++;
      @(negedge clk);
    end
    cmd_valid = 1'b0;
    chk(16'(k), 16'(tw_pkg::CMDQ_DEPTH));
    chk(cmd_ready, 1'b0);
    wait_rsp();
    chk(rsp.ack, 1'b1);
    hs = hl;
    ls = ll;
    stretch = 16'h0000;
    for (int i = 0; i < tw_pkg::CMDQ_DEPTH; i++) begin
      wait_rsp();
      chk({rsp.ack, rsp.data}, {1'b1, 8'h3C});
    end
    chk(16'(ls > 400), 16'h0001);
    chk(16'(hl), 16'(hs));
    chk(cmd_ready, 1'b1);
    push(P, 8'h00, 1'b0);
    repeat (80) @(negedge clk);
    $display("fill and stretch test done");
    push(S, 8'h00, 1'b0);
    push(W, 8'hFF, 1'b0);
    for (k = 0; k < 2000 && !(bus_owned === 1'b1 && scl_w === 1'b0); k++)
      @(negedge clk);
    rival = 1'b1;
    wait_rsp();
    chk(rsp.lost, 1'b1);
    repeat (4) @(negedge clk);
    chk({scl_oe, sda_oe, bus_owned, bus_busy}, 4'h1);
    // The winner ends its transfer with a STOP
    rival = 1'b0;
    repeat (10) @(negedge clk);
    chk(bus_busy, 1'b0);
    push(S, 8'h00, 1'b0);
    push(W, AW, 1'b0);
    wait_rsp();
    chk({rsp.ack, rsp.lost}, 2'h2);
    push(P, 8'h00, 1'b0);
    repeat (80) @(negedge clk);
    chk({bus_busy, bus_owned}, 2'h0);
    // Loss with restart: the master waits for the STOP, then replays
    retry_on_loss = 1'b1;
    push(S, 8'h00, 1'b0);
    push(W, 8'hFF, 1'b0);
    for (k = 0; k < 2000 && !(bus_owned === 1'b1 && scl_w === 1'b0); k++)
      @(negedge clk);
    rival = 1'b1;
    wait_rsp();
    chk(rsp.lost, 1'b1);
    repeat (4) @(negedge clk);
    chk({bus_owned, bus_busy}, 2'h1);
    rival = 1'b0;
    wait_rsp();
    // Replayed address matches no slave, so it reads back with a nack
    chk({rsp.data, rsp.ack, rsp.lost}, {8'hFF, 2'h0});
    push(P, 8'h00, 1'b0);
    repeat (80) @(negedge clk);
    chk({bus_busy, bus_owned}, 2'h0);
    $display("arbitration test done");
    conclude();
  end
endmodule
`default_nettype wire

/* File: test/tw_slave_model.sv */
// Behavioural bus slave: address match, acknowledge, read data, stretching.
`default_nettype none
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic        clk,
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] stretch,
  input  wire logic [7:0]  rd_byte,
  output logic             scl_oe,
  output logic             sda_oe,
  output logic      [7:0]  got
);
  logic        scl_q = 1'b1;
  logic        sda_q = 1'b1;
  logic        sel = 1'b0;
  logic        rd = 1'b0;
  logic        first = 1'b0;
  logic [15:0] st_cnt = 16'h0000;
  int          bitn = -1;
  int          nb;
  logic        fst;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    got = 8'h00;
  end

  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    nb = (bitn == 8) ? 0 : bitn + 1;
    fst = first && bitn != 8;
    if (scl && scl_q && sda_q && !sda) begin
      bitn <= -1;
      first <= 1'b1;
      sel <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      bitn <= -1;
      first <= 1'b0;
      sel <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl && !scl_q) begin
      if (bitn >= 0 && bitn < 8) got <= {got[6:0], sda};
      else if (bitn == 8 && rd && sel && sda) sel <= 1'b0;
    end else if (!scl && scl_q) begin
      bitn <= nb;
      if (bitn == 8) first <= 1'b0;
      if (fst && nb == 8) begin
        sel <= (got[7:1] == ADDR);
        rd <= got[0];
        sda_oe <= (got[7:1] == ADDR);
      end else if (nb == 8) sda_oe <= !rd && sel;
      else sda_oe <= !fst && rd && sel && !rd_byte[7 - nb];
    end
    // hold the clock low after each fall
    if (!scl && scl_q) begin
      st_cnt <= stretch;
      scl_oe <= (stretch != 16'h0000);
    end else if (st_cnt != 16'h0000) begin
      st_cnt <= st_cnt - 16'h0001;
      scl_oe <= (st_cnt > 16'h0001);
    end
  end
endmodule
`default_nettype wire
